// *** hdl/sadc_engine.sv ***
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/100ps
// Converter control: register file, sequencing, successive approximation
//
// Contract
// - Every conversion lasts exactly 32 conversion clocks, clock at least 1 MHz.
// - Stop mode turns the RC oscillator off; power-on bit stays set.
// - RC-domain results enter the result register in step with the bus clock.
// - Done flag sets when a conversion finishes; result is then valid.
// - Done flag clears on control write or result read; control write restarts.
// - After a control write, selected input converts every 32 cycles, repeatedly.
// - Each result overwrites the previous one; no overrun indication.
// - RC select bit clocks conversions from the internal oscillator.
// - Power-on bit enables current sources and charge pump; settling time applies.
// - Codes 00-04 pick pins; 10, 11, 12 pick high, mid, low reference.
// - Code 13 is factory test and converts to zero.
// - High reference gives FF, low gives 00, above high saturates at FF.
// - One 8-bit result register, loaded each time the done flag sets.
// - Input is sampled at start of each period, then compared successively.
// - Wait mode keeps converting and does not clear the done flag.
// - Stop mode halts the converter and abandons a conversion without result.
// - Stop mode leaves result and control/status registers unchanged.
module sadc_engine
    import sadc_pkg::*;
(
    input  wire logic         ref_clk_in,
    input  wire logic         srst_in,
    input  wire logic [3:0]   avs_address_in,
    input  wire logic         avs_read_in,
    input  wire logic         avs_write_in,
    input  wire logic [31:0]  avs_writedata_in,
    input  wire logic [3:0]   avs_byteenable_in,
    output logic      [31:0]  avs_readdata_out,
    output logic              avs_waitrequest_out,
    input  wire logic         stop_mode_in,
    input  wire logic         wait_mode_in,
    input  wire logic         rc_osc_in,
    input  wire logic         comp_above_in,
    output logic      [4:0]   input_select_field_out,
    output logic              sample_hold_out,
    output logic      [7:0]   dac_code_out,
    output logic              converter_power_on_out,
    output logic              rc_osc_enable_out,
    output logic              settled_out
);
    import sadc_pkg::*;

    sadc_tick_if tick_if ();

    logic [7:0]  converter_control_status;
    logic [7:0]  converter_result;
    logic        conversion_done_flag;
    logic        comp_meta;
    logic        comp_sync;
    logic        waitreq;
    sadc_state_t state;
    logic [4:0]  cycle_count;
    logic [7:0]  trial;
    logic [3:0]  bit_idx;
    logic        finish;
    logic [7:0]  final_code;
    logic        csr_write;
    logic        result_read;
    logic        run;
    logic [10:0] settle_count;

    function automatic logic is_fixed_code(input logic [4:0] sel);
        is_fixed_code = (sel == SADC_SEL_VHIGH) || (sel == SADC_SEL_VLOW) || (sel == SADC_SEL_TEST);
    endfunction : is_fixed_code

    function automatic logic [7:0] fixed_value(input logic [4:0] sel);
        if (sel == SADC_SEL_VHIGH)
            fixed_value = SADC_FULL_SCALE;
        else
            fixed_value = SADC_ZERO_SCALE;
    endfunction : fixed_value

    // Waitrequest drops for one cycle per access, so every access takes two edges
    wire access = (avs_read_in || avs_write_in);
    assign csr_write   = avs_write_in && !waitreq && avs_address_in == SADC_CSR_ADDR && avs_byteenable_in[0];
    assign result_read = avs_read_in && !waitreq && avs_address_in == SADC_RESULT_ADDR;

    wire [4:0] sel_field = converter_control_status[SADC_SEL_LSB +: SADC_SEL_W];
    wire       pon       = converter_control_status[SADC_PON_BIT];
    wire       rcs       = converter_control_status[SADC_RCS_BIT];
    assign run = pon && !stop_mode_in;

    sadc_clk_gen u_clk_gen (
        .ref_clk_in   (ref_clk_in),
        .srst_in      (srst_in),
        .rc_osc_in    (rc_osc_in),
        .rc_select_in (rcs),
        .run_in       (run),
        .tick_if      (tick_if)
    );

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            waitreq <= 1'b1;
        else
            waitreq <= !(access && waitreq);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            avs_readdata_out <= SADC_UNMAPPED_DATA;
        else if (avs_read_in && waitreq)
        begin
            unique case (avs_address_in)
                SADC_CSR_ADDR:    avs_readdata_out <= {24'h000000, conversion_done_flag,
                                                       converter_control_status[6:0]};
                SADC_RESULT_ADDR: avs_readdata_out <= {24'h000000, converter_result};
                default:          avs_readdata_out <= SADC_UNMAPPED_DATA;
            endcase
        end
    end

    // Control/status: stop mode does not touch it
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            converter_control_status <= SADC_CSR_RESET;
        else if (csr_write)
            converter_control_status <= {1'b0, avs_writedata_in[6:0]};
    end

    // Comparator is asynchronous to the bus clock
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end
        else
        begin
            comp_meta <= comp_above_in;
            comp_sync <= comp_meta;
        end
    end

    // Sequencer: one sample cycle plus 31 approximation cycles per conversion
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || !run || csr_write)
        begin
            state       <= SADC_IDLE;
            cycle_count <= 5'h00;
            trial       <= SADC_MID_SCALE;
            bit_idx     <= 4'h7;
        end
        else if (tick_if.tick)
        begin
            unique case (state)
                SADC_IDLE:
                begin
                    state       <= SADC_SAMPLE;
                    cycle_count <= 5'h00;
                end
                SADC_SAMPLE:
                begin
                    state       <= SADC_APPROX;
                    cycle_count <= 5'h01;
                    trial       <= SADC_MID_SCALE;
                    bit_idx     <= 4'h7;
                end
                SADC_APPROX:
                begin
                    // Resolve one bit every fourth cycle, leaving settling time for the DAC;
                    // the last bit lands one cycle before the result is taken
                    if (cycle_count[1:0] == 2'b10 && bit_idx != 4'hf)
                    begin
                        if (!comp_sync)
                            trial[bit_idx[2:0]] <= 1'b0;
                        if (bit_idx != 4'h0)
                            trial[bit_idx[2:0] - 3'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                    if (cycle_count == 5'(SADC_CONV_CYCLES - 1))
                    begin
                        state       <= SADC_SAMPLE;
                        cycle_count <= 5'h00;
                    end
                    else
                        cycle_count <= cycle_count + 5'h01;
                end
            endcase
        end
    end

    assign finish = tick_if.tick && run && !csr_write && state == SADC_APPROX
                    && cycle_count == 5'(SADC_CONV_CYCLES - 1);
    // Above-range inputs keep every trial bit set, saturating at full scale
    assign final_code = is_fixed_code(sel_field) ? fixed_value(sel_field) : trial;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            converter_result <= SADC_RESULT_RESET;
        else if (finish)
            converter_result <= final_code;
    end

    // Set wins over clear; wait mode has no effect on the flag
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            conversion_done_flag <= 1'b0;
        else if (finish)
            conversion_done_flag <= 1'b1;
        else if (csr_write || result_read)
            conversion_done_flag <= 1'b0;
    end

    // Settling indicator for power-on and oscillator start
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || !run || csr_write)
            settle_count <= 11'h000;
        else if (settle_count != 11'(SADC_SETTLE_CYCLES))
            settle_count <= settle_count + 11'h001;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            input_select_field_out <= 5'h00;
            sample_hold_out        <= 1'b0;
            dac_code_out           <= SADC_MID_SCALE;
            converter_power_on_out <= 1'b0;
            rc_osc_enable_out      <= 1'b0;
            settled_out            <= 1'b0;
            avs_waitrequest_out    <= 1'b1;
        end
        else
        begin
            input_select_field_out <= sel_field;
            sample_hold_out        <= (state == SADC_SAMPLE) && run;
            dac_code_out           <= trial;
            converter_power_on_out <= pon && !stop_mode_in;
            rc_osc_enable_out      <= rcs && !stop_mode_in;
            settled_out            <= settle_count == 11'(SADC_SETTLE_CYCLES);
            avs_waitrequest_out    <= !(access && waitreq && !(avs_waitrequest_out == 1'b0));
        end
    end

    logic unused_wait;
    assign unused_wait = wait_mode_in;

endmodule : sadc_engine

// *** hdl/sadc_pkg.sv ***
package sadc_pkg;

    // Register byte addresses (word aligned)
    localparam logic [3:0] SADC_CSR_ADDR    = 4'h0;
    localparam logic [3:0] SADC_RESULT_ADDR = 4'h4;

    // Control/status field positions
    localparam int SADC_SEL_LSB  = 0;
    localparam int SADC_SEL_W    = 5;
    localparam int SADC_PON_BIT  = 5;
    localparam int SADC_RCS_BIT  = 6;
    localparam int SADC_DONE_BIT = 7;

    localparam logic [7:0] SADC_CSR_RESET    = 8'h00;
    localparam logic [7:0] SADC_RESULT_RESET = 8'h00;
    localparam logic [31:0] SADC_UNMAPPED_DATA = 32'h0000_0000;

    // Conversion timing
    localparam int SADC_CONV_CYCLES = 32;
    localparam int SADC_CLK_MHZ     = 100;
    localparam int SADC_MIN_CONV_MHZ = 1;
    // Bus-clock divider giving a conversion clock at or above the minimum rate
    localparam int SADC_BUS_DIV = SADC_CLK_MHZ / SADC_MIN_CONV_MHZ;
    localparam int SADC_SETTLE_NS = 10000;
    localparam int SADC_SETTLE_CYCLES = (SADC_SETTLE_NS * SADC_CLK_MHZ + 999) / 1000;

    // Selector codes
    localparam logic [4:0] SADC_SEL_PIN_MAX = 5'h04;
    localparam logic [4:0] SADC_SEL_VHIGH   = 5'h10;
    localparam logic [4:0] SADC_SEL_VMID    = 5'h11;
    localparam logic [4:0] SADC_SEL_VLOW    = 5'h12;
    localparam logic [4:0] SADC_SEL_TEST    = 5'h13;

    localparam logic [7:0] SADC_FULL_SCALE = 8'hff;
    localparam logic [7:0] SADC_ZERO_SCALE = 8'h00;
    localparam logic [7:0] SADC_MID_SCALE  = 8'h80;

    typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_APPROX} sadc_state_t;

endpackage : sadc_pkg

// *** hdl/sadc_tick_if.sv ***
`timescale 1ns/100ps
interface sadc_tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface : sadc_tick_if

// *** hdl/sadc_clk_gen.sv ***
`timescale 1ns/100ps
// Conversion clock enable: divided bus clock, or the synchronised RC oscillator edge
module sadc_clk_gen
    import sadc_pkg::*;
(
    input  wire logic   ref_clk_in,
    input  wire logic   srst_in,
    input  wire logic   rc_osc_in,
    input  wire logic   rc_select_in,
    input  wire logic   run_in,
    sadc_tick_if.source tick_if
);
    import sadc_pkg::*;

    logic [6:0] div_count;
    logic       rc_meta;
    logic       rc_sync;
    logic       rc_prev;

    // Oscillator runs only when selected and not stopped
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_prev <= 1'b0;
        end
        else
        begin
            rc_meta <= rc_osc_in;
            rc_sync <= rc_meta;
            rc_prev <= rc_sync;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || !run_in || div_count == 7'(SADC_BUS_DIV - 1))
            div_count <= 7'h00;
        else
            div_count <= div_count + 7'h01;
    end

    always_comb
    begin
        if (!run_in)
            tick_if.tick = 1'b0;
        else if (rc_select_in)
            tick_if.tick = rc_sync && !rc_prev;
        else
            tick_if.tick = (div_count == 7'(SADC_BUS_DIV - 1));
    end

endmodule : sadc_clk_gen

// *** dv/sadc_monitor.sv ***
`timescale 1ns/100ps
module sadc_monitor
    import sadc_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        srst_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        stop_mode_in,
    input wire logic [4:0]  input_select_field_out,
    input wire logic        converter_power_on_out,
    input wire logic        rc_osc_enable_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    sequence wr_csr_s;
        avs_write_in && !avs_waitrequest_out && avs_address_in == SADC_CSR_ADDR && avs_byteenable_in[0];
    endsequence
    sequence rd_s;
        avs_read_in && !avs_waitrequest_out;
    endsequence
    // Outputs are allowed up to two registers of lag after the write lands
    sequence wr_settled_s;
        wr_csr_s ##1 !stop_mode_in ##1 !stop_mode_in;
    endsequence
    chk_wait_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    chk_answer_latency: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("access not answered in one cycle");
    chk_stop_power_off: assert property (stop_mode_in |=> !converter_power_on_out && !rc_osc_enable_out)
        else $error("converter still powered in stop");
    // A write landing just before stop still moves the selector one register later
    chk_stop_keeps_select: assert property (stop_mode_in && !avs_write_in && !$past(avs_write_in)
        |=> $stable(input_select_field_out)) else $error("selector changed in stop");
    chk_select_follows: assert property (wr_csr_s ##2 1'h1 |-> input_select_field_out == $past(avs_writedata_in[4:0], 2))
        else $error("selector not taken from write");
    chk_power_follows: assert property (wr_settled_s |-> converter_power_on_out == $past(avs_writedata_in[5], 2))
        else $error("power-on output wrong");
    chk_rc_follows: assert property (wr_settled_s |-> rc_osc_enable_out == $past(avs_writedata_in[6], 2))
        else $error("oscillator enable wrong");
    chk_unmapped_zero: assert property (rd_s ##0 (avs_address_in != SADC_CSR_ADDR && avs_address_in != SADC_RESULT_ADDR)
        |-> avs_readdata_out == SADC_UNMAPPED_DATA) else $error("unmapped read not zero");
    chk_upper_bits_zero: assert property (rd_s |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data above byte not zero");
endmodule : sadc_monitor

bind sadc_engine sadc_monitor mon (.*);

// *** dv/sadc_analog_model.sv ***
`timescale 1ns/100ps
module sadc_analog_model (
    input wire logic       ref_clk_in,
    input wire logic [4:0] sel_in,
    input wire logic [7:0] dac_in,
    input wire logic       hold_in,
    input wire logic       power_in,
    input wire logic       rc_en_in,
    output logic           comp_above_out,
    output logic           rc_osc_out
);
    logic [8:0] held = 9'h0;
    logic       over = 1'h0;
    initial comp_above_out = 1'h0;
    initial rc_osc_out = 1'h0;
    // Stands still while disabled, runs free of the bus clock when enabled
    always
    begin
        #333.3;
        if (rc_en_in) rc_osc_out = ~rc_osc_out;
    end
    // Half an LSB added so a level converts to itself whatever the compare sense
    always @(posedge ref_clk_in)
    begin
        if (hold_in)
        begin
            over <= sel_in == 5'h04;
            case (sel_in)
                5'h00: held <= 9'h025;
                5'h01: held <= 9'h0b5;
                5'h02: held <= 9'h14b;
                5'h03: held <= 9'h079;
                5'h10: held <= 9'h1ff;
                5'h11: held <= 9'h101;
                default: held <= 9'h001;
            endcase
        end
        // Unpowered comparator output is not trusted
        comp_above_out <= power_in ? (over || {dac_in, 1'h0} < held) : ~comp_above_out;
    end
endmodule : sadc_analog_model

// *** dv/test_sadc_engine.sv ***
`timescale 1ns/100ps
module test_sadc_engine;
    import sadc_pkg::*;
    logic ref_clk_in = 1'h0, srst_in = 1'h1, avs_read_in = 1'h0, avs_write_in = 1'h0;
    logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic avs_waitrequest_out, stop_mode_in = 1'h0, wait_mode_in = 1'h0, rc_osc_in, comp_above_in;
    logic [4:0] input_select_field_out;
    logic sample_hold_out, converter_power_on_out, rc_osc_enable_out, settled_out;
    logic [7:0] dac_code_out;
    int num_errors = 0, n_tests = 0;
    logic [4:0] sel [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13};
    logic [7:0] exp_res [9] = '{8'h12, 8'h5a, 8'ha5, 8'h3c, 8'hff, 8'hff, 8'h80, 8'h00, 8'h00};
    always #5 ref_clk_in = ~ref_clk_in;
    sadc_engine uut (.*);
    sadc_analog_model model (.ref_clk_in(ref_clk_in), .sel_in(input_select_field_out), .dac_in(dac_code_out),
        .hold_in(sample_hold_out), .power_in(converter_power_on_out), .rc_en_in(rc_osc_enable_out),
        .comp_above_out(comp_above_in), .rc_osc_out(rc_osc_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_address_in <= a;
        avs_writedata_in <= d;
        @(posedge ref_clk_in);
        while (avs_waitrequest_out !== 1'h0) @(posedge ref_clk_in);
        rd = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
        @(posedge ref_clk_in);
    endtask : bus
    task automatic poll;
        repeat (3000)
        begin
            bus(1'h0, SADC_CSR_ADDR, 32'h0);
            if (rd[7] === 1'h1) break;
        end
        check(rd[7], 1'h1);
    endtask : poll
    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        #950us;
        num_errors++;
        wrap_up;
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'h0;
        @(posedge ref_clk_in);
        bus(1'h0, SADC_CSR_ADDR, 32'h0);
        check(rd, {24'h0, SADC_CSR_RESET});
        bus(1'h0, SADC_RESULT_ADDR, 32'h0);
        check(rd, {24'h0, SADC_RESULT_RESET});
        bus(1'h1, 4'h8, 32'hff);
        bus(1'h0, 4'h8, 32'h0);
        check(rd, SADC_UNMAPPED_DATA);
        // A write without the low byte lane must be ignored
        avs_byteenable_in <= 4'he;
        bus(1'h1, SADC_CSR_ADDR, 32'h3f);
        avs_byteenable_in <= 4'hf;
        bus(1'h0, SADC_CSR_ADDR, 32'h0);
        check(rd, {24'h0, SADC_CSR_RESET});
        $display("registers finished");
        for (int i = 0; i < 9; i++)
        begin
            bus(1'h1, SADC_CSR_ADDR, {26'h0, 1'h1, sel[i]});
            poll;
            check(settled_out, 1'h1);
            bus(1'h0, SADC_RESULT_ADDR, 32'h0);
            check(rd, exp_res[i]);
            bus(1'h0, SADC_CSR_ADDR, 32'h0);
            check(rd, {27'h1, sel[i]});
        end
        $display("channels finished");
        poll;
        bus(1'h0, SADC_RESULT_ADDR, 32'h0);
        check(rd, 32'h0);
        poll;
        bus(1'h1, SADC_CSR_ADDR, 32'h21);
        bus(1'h0, SADC_CSR_ADDR, 32'h0);
        check(rd, 32'h21);
        $display("continuous finished");
        wait_mode_in <= 1'h1;
        poll;
        bus(1'h0, SADC_RESULT_ADDR, 32'h0);
        check(rd, 32'h5a);
        wait_mode_in <= 1'h0;
        $display("wait finished");
        stop_mode_in <= 1'h1;
        repeat (4000) @(posedge ref_clk_in);
        check(converter_power_on_out, 1'h0);
        check(settled_out, 1'h0);
        bus(1'h0, SADC_CSR_ADDR, 32'h0);
        check(rd, 32'h21);
        bus(1'h0, SADC_RESULT_ADDR, 32'h0);
        check(rd, 32'h5a);
        stop_mode_in <= 1'h0;
        $display("stop finished");
        bus(1'h1, SADC_CSR_ADDR, 32'h61);
        @(posedge ref_clk_in);
        check(rc_osc_enable_out, 1'h1);
        poll;
        bus(1'h0, SADC_RESULT_ADDR, 32'h0);
        check(rd, 32'h5a);
        stop_mode_in <= 1'h1;
        repeat (3) @(posedge ref_clk_in);
        check(rc_osc_enable_out, 1'h0);
        check(converter_power_on_out, 1'h0);
        bus(1'h0, SADC_CSR_ADDR, 32'h0);
        check(rd, 32'h61);
        stop_mode_in <= 1'h0;
        bus(1'h1, SADC_CSR_ADDR, 32'h0);
        $display("oscillator finished");
        wrap_up;
    end
endmodule : test_sadc_engine
